/* rtl/celm_pkg.sv */
// constants for the core enable and level meter register bank
`default_nettype none
package celm_pkg;
    localparam logic [5:0] CELM_IDX_CORE_ENABLE = 6'h0b;
    localparam logic [5:0] CELM_IDX_LEVEL_0 = 6'h0c;
    localparam logic [5:0] CELM_IDX_LEVEL_1 = 6'h0d;
    localparam logic [5:0] CELM_IDX_LEVEL_2 = 6'h0e;
    localparam int CELM_BIT_CLK_GATE = 0;
    localparam int CELM_BIT_LIMITER_ENABLE = 1;
    localparam logic [7:0] CELM_CORE_ENABLE_RST = 8'h03;
    localparam logic [7:0] CELM_LEVEL_RST = 8'h00;
    localparam logic [7:0] CELM_CORE_ENABLE_MASK = 8'h03;
    localparam logic [9:0] CELM_COEF_LO = 10'h0e0;
    localparam logic [9:0] CELM_COEF_HI = 10'h2bf;
    localparam int CELM_LEVEL_IN_W = 16;
    localparam int CELM_GAIN_W = 24;
    localparam logic [23:0] CELM_MAX_GAIN = 24'h80_0000;
    localparam int CELM_PARAM_AW = 10;
    localparam int CELM_PARAM_DW = 32;
endpackage
`default_nettype wire

/* rtl/celm_core_enable_meters.sv */
// core enable controls, limiter gain select and three level meters
//
// How it works
// - clearing the limiter enable stops only attack; decay stays on always.
// - with the limiter off, limiter instructions get a fixed maximum gain.
// - limiter enable is bit 1 of the core enable register, reset 1.
// - bit 0 gates the core clock directly, 0 stops it, reset 1.
// - coefficient writes to 0x0e0..0x2bf are dropped while bit 0 is 0.
// - three 8-bit level registers at 0x0c..0x0e hold dB codes of core data.
// - codes are linear in dB, 0 is -96 dB, 16 codes per 6 dB.
// - level registers are read-only on the bus and reset to 0x00.
// - run control changes the running state only at program start.
//
// Register access over Avalon-MM is this design's own decision.
`default_nettype none
module celm_core_enable_meters
    import celm_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,

    input wire logic level_wr_in,
    input wire logic [1:0] level_sel_in,
    input wire logic [CELM_LEVEL_IN_W-1:0] level_value_in,

    input wire logic [CELM_GAIN_W-1:0] lim_gain_in,
    output logic [CELM_GAIN_W-1:0] lim_gain_out,
    output logic lim_attack_en_out,
    output logic lim_decay_en_out,
    output logic core_clk_en_out,

    input wire logic param_wr_in,
    input wire logic [CELM_PARAM_AW-1:0] param_addr_in,
    input wire logic [CELM_PARAM_DW-1:0] param_data_in,
    output logic param_wr_out,
    output logic [CELM_PARAM_AW-1:0] param_addr_out,
    output logic [CELM_PARAM_DW-1:0] param_data_out,

    input wire logic core_run_in,
    input wire logic prog_start_in,
    output logic core_running_out
);
    typedef struct packed {
        logic [7:0] core_enable;
        logic [7:0] level_meter_0;
        logic [7:0] level_meter_1;
        logic [7:0] level_meter_2;
        logic wait_n;
        logic [31:0] rdata;
        logic [CELM_GAIN_W-1:0] gain;
        logic attack;
        logic decay;
        logic clk_en;
        logic pwr;
        logic [CELM_PARAM_AW-1:0] paddr;
        logic [CELM_PARAM_DW-1:0] pdata;
        logic running;
    } celm_state_t;

    celm_state_t st_r;
    celm_state_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;

    // approximate log2: msb position in the high nibble, next bits below
    // truncates, so steps finer than one sixteenth of 6 dB are lost
    function automatic logic [7:0] celm_db_code(
        input logic [CELM_LEVEL_IN_W-1:0] v
    );
        logic [3:0] p;
        logic [CELM_LEVEL_IN_W+3:0] t;
        p = 4'h0;
        t = '0;
        for (int i = 0; i < CELM_LEVEL_IN_W; i++)
        begin
            if (v[i])
            begin
                p = 4'(i);
            end
        end
        t = {v, 4'h0} >> p;
        if (v == '0)
        begin
            celm_db_code = 8'h00;
        end
        else
        begin
            celm_db_code = {p, t[3:0]};
        end
    endfunction

    function automatic logic celm_in_coef(
        input logic [CELM_PARAM_AW-1:0] a
    );
        celm_in_coef = (a >= CELM_COEF_LO) && (a <= CELM_COEF_HI);
    endfunction

    // unmapped words and the upper 24 bits always read zero
    function automatic logic [31:0] celm_read_mux(
        input logic [5:0] i,
        input logic [7:0] ce,
        input logic [7:0] m0,
        input logic [7:0] m1,
        input logic [7:0] m2
    );
        logic [7:0] b;
        b = 8'h00;
        case (i)
            CELM_IDX_CORE_ENABLE:
            begin
                b = ce;
            end
            CELM_IDX_LEVEL_0:
            begin
                b = m0;
            end
            CELM_IDX_LEVEL_1:
            begin
                b = m1;
            end
            CELM_IDX_LEVEL_2:
            begin
                b = m2;
            end
            default:
            begin
                b = 8'h00;
            end
        endcase
        celm_read_mux = {24'h00_0000, b};
    endfunction

    // select 3 has no meter, so a write there is lost on purpose
    function automatic logic celm_meter_hit(
        input logic wr,
        input logic [1:0] s,
        input logic [1:0] n
    );
        celm_meter_hit = wr && (s == n) && (s != 2'd3);
    endfunction

    // fixed maximum gain stands in for the computed gain when off
    function automatic logic [CELM_GAIN_W-1:0] celm_gain_pick(
        input logic on,
        input logic [CELM_GAIN_W-1:0] g
    );
        celm_gain_pick = on ? g : CELM_MAX_GAIN;
    endfunction

    // a gated core cannot take coefficient writes
    function automatic logic celm_param_pass(
        input logic wr,
        input logic [CELM_PARAM_AW-1:0] a,
        input logic gate_on
    );
        celm_param_pass = wr && (gate_on || !celm_in_coef(a));
    endfunction

    // bits 7..2 have no storage behind them, so they read back zero
    function automatic logic [7:0] celm_ce_value(
        input logic [7:0] w
    );
        celm_ce_value = w & CELM_CORE_ENABLE_MASK;
    endfunction

    // both flops clear at once; release takes two edges
    always_ff @(posedge core_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_sync_r <= 2'b00;
        end
        else
        begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    always_comb
    begin
        logic [5:0] idx;
        logic lim_on;
        logic [7:0] code;
        logic take;
        logic commit;

        idx = avs_address_in[7:2];
        lim_on = 1'b0;
        code = 8'h00;
        take = 1'b0;
        commit = 1'b0;
        st_nxt = st_r;
        st_nxt.wait_n = 1'b0;

        // one wait state: a request is taken while waitrequest is high
        take = (avs_read_in || avs_write_in) && !st_r.wait_n;
        // a write lands only on the edge the master sees waitrequest low
        commit = avs_write_in && !avs_read_in && st_r.wait_n;
        if (take)
        begin
            st_nxt.wait_n = 1'b1;
            st_nxt.rdata = 32'h0000_0000;
            if (avs_read_in)
            begin
                st_nxt.rdata = celm_read_mux(idx, st_r.core_enable,
                                             st_r.level_meter_0,
                                             st_r.level_meter_1,
                                             st_r.level_meter_2);
            end
        end

        if (commit && avs_byteenable_in[0]
            && idx == CELM_IDX_CORE_ENABLE)
        begin
            st_nxt.core_enable = celm_ce_value(avs_writedata_in[7:0]);
        end
        // level meters ignore bus writes

        // core side writes convert to dB codes
        code = celm_db_code(level_value_in);
        if (celm_meter_hit(level_wr_in, level_sel_in, 2'd0))
        begin
            st_nxt.level_meter_0 = code;
        end
        if (celm_meter_hit(level_wr_in, level_sel_in, 2'd1))
        begin
            st_nxt.level_meter_1 = code;
        end
        if (celm_meter_hit(level_wr_in, level_sel_in, 2'd2))
        begin
            st_nxt.level_meter_2 = code;
        end

        lim_on = st_nxt.core_enable[CELM_BIT_LIMITER_ENABLE];
        st_nxt.attack = lim_on;
        // decay never stops so a gain ramp in flight finishes safely
        st_nxt.decay = 1'b1;
        st_nxt.gain = celm_gain_pick(lim_on, lim_gain_in);
        // enable flop feeds the clock gate cell straight through
        st_nxt.clk_en = st_nxt.core_enable[CELM_BIT_CLK_GATE];
        st_nxt.pwr = celm_param_pass(param_wr_in, param_addr_in,
            st_r.core_enable[CELM_BIT_CLK_GATE]);
        st_nxt.paddr = param_addr_in;
        st_nxt.pdata = param_data_in;

        // run changes land only at a pass boundary, never mid-program
        if (prog_start_in)
        begin
            st_nxt.running = core_run_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_r <= '0;
            st_r.core_enable <= CELM_CORE_ENABLE_RST;
            st_r.level_meter_0 <= CELM_LEVEL_RST;
            st_r.level_meter_1 <= CELM_LEVEL_RST;
            st_r.level_meter_2 <= CELM_LEVEL_RST;
            st_r.gain <= '0;
            st_r.attack <= 1'b1;
            st_r.decay <= 1'b1;
            st_r.clk_en <= 1'b1;
            st_r.wait_n <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            st_r.pwr <= 1'b0;
            st_r.paddr <= '0;
            st_r.pdata <= '0;
            st_r.running <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_out = st_r.rdata;
    assign avs_waitrequest_out = !st_r.wait_n;

    assign lim_gain_out = st_r.gain;
    assign lim_attack_en_out = st_r.attack;
    assign lim_decay_en_out = st_r.decay;
    assign core_clk_en_out = st_r.clk_en;

    assign param_wr_out = st_r.pwr;
    assign param_addr_out = st_r.paddr;
    assign param_data_out = st_r.pdata;
    assign core_running_out = st_r.running;
endmodule
`default_nettype wire

/* dv/celm_core_enable_meters_props.sv */
// assertion checker for the core enable and level meter bank
`default_nettype none
module celm_core_enable_meters_props
    import celm_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rstn_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [CELM_GAIN_W-1:0] lim_gain_out,
    input wire logic lim_attack_en_out,
    input wire logic lim_decay_en_out,
    input wire logic core_clk_en_out,
    input wire logic param_wr_in,
    input wire logic [CELM_PARAM_AW-1:0] param_addr_in,
    input wire logic param_wr_out,
    input wire logic prog_start_in,
    input wire logic core_running_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    wire ce_acc = !avs_waitrequest_out && avs_address_in == 8'h2c;
    wire in_coef = param_addr_in >= CELM_COEF_LO
        && param_addr_in <= CELM_COEF_HI;
    decay_on_a: assert property (lim_decay_en_out)
        else $error("decay off");
    fixed_gain_a: assert property (!lim_attack_en_out [*2] |->
        lim_gain_out == CELM_MAX_GAIN) else $error("gain not max");
    attack_bit_a: assert property (ce_acc && avs_write_in |=>
        lim_attack_en_out == $past(avs_writedata_in[1]))
        else $error("attack");
    clk_gate_a: assert property (ce_acc && avs_write_in |=>
        core_clk_en_out == $past(avs_writedata_in[0])) else $error("gate");
    unused_zero_a: assert property (ce_acc && avs_read_in |->
        avs_readdata_out == {30'h0, lim_attack_en_out, core_clk_en_out})
        else $error("enable readback");
    coef_block_a: assert property (param_wr_in && in_coef
        && !core_clk_en_out |=> !param_wr_out)
        else $error("coef not blocked");
    coef_pass_a: assert property (param_wr_in && !in_coef |=>
        param_wr_out) else $error("param dropped");
    run_hold_a: assert property (!prog_start_in |=>
        $stable(core_running_out)) else $error("run changed");
endmodule
bind celm_core_enable_meters celm_core_enable_meters_props
    i_celm_core_enable_meters_props (.*);
`default_nettype wire

/* dv/celm_core_enable_meters_bench.sv */
// self-checking bench for the core enable and level meter bank
`default_nettype none
module celm_core_enable_meters_bench;
    import celm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, rd = 0, wr = 0, lw = 0, pw = 0, run = 0, ps = 0;
    logic [7:0] adr = 0, wd = 0;
    logic [1:0] sel = 0;
    logic [15:0] lv = 0;
    logic [9:0] pa = 0;
    logic [31:0] q, rdat;
    logic wt, att, dec, cke, pwo, runo;
    logic [23:0] gain;
    int errors = 0, checked = 0;
    always #20 clk = !clk;
    celm_core_enable_meters i_celm_core_enable_meters (.core_clk_in(clk),
        .rstn_in(rstn), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in({24'h00_0000, wd}),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wt), .level_wr_in(lw), .level_sel_in(sel),
        .level_value_in(lv), .lim_gain_in(24'h12_3456), .lim_gain_out(gain),
        .lim_attack_en_out(att), .lim_decay_en_out(dec),
        .core_clk_en_out(cke), .param_wr_in(pw), .param_addr_in(pa),
        .param_data_in(32'h0000_0000), .param_wr_out(pwo),
        .param_addr_out(), .param_data_out(), .core_run_in(run),
        .prog_start_in(ps), .core_running_out(runo));
    task chk(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    // waitrequest and read data are taken at the same rising edge
    task bus(input logic w, input logic [7:0] a, d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 0;
        rd <= 0;
    endtask
    task prm(input logic [9:0] a, input logic e);
        @(posedge clk);
        pw <= 1;
        pa <= a;
        @(posedge clk);
        pw <= 0;
        @(negedge clk);
        chk("param_wr", pwo, e);
    endtask
    task lvl(input logic [1:0] s, input logic [15:0] v);
        @(posedge clk);
        lw <= 1;
        sel <= s;
        lv <= v;
        @(posedge clk);
        lw <= 0;
    endtask
    task t_gate;
        bus(0, 8'h2c, 0);
        chk("enable", q, 32'h0000_0003);
        bus(1, 8'h2c, 8'hfc);
        bus(0, 8'h2c, 0);
        chk("enable", q, 32'h0000_0000);
        chk("clk_en", cke, 0);
        chk("gain", gain, CELM_MAX_GAIN);
        chk("decay", dec, 1);
        prm(10'h0df, 1);
        prm(10'h0e0, 0);
        prm(10'h2bf, 0);
        prm(10'h2c0, 1);
        bus(1, 8'h2c, 8'h03);
        prm(10'h0e0, 1);
        chk("gain", gain, 32'h0012_3456);
        $display("gate test done");
    endtask
    task t_meters;
        bus(0, 8'h34, 0);
        chk("meter1", q, 0);
        lvl(0, 16'hffff);
        lvl(1, 16'h0100);
        lvl(2, 16'h0018);
        bus(1, 8'h30, 8'h55);
        bus(0, 8'h30, 0);
        chk("meter0", q, 32'h0000_00ff);
        bus(0, 8'h34, 0);
        chk("meter1", q, 32'h0000_0080);
        bus(0, 8'h38, 0);
        chk("meter2", q, 32'h0000_0048);
        bus(0, 8'h3c, 0);
        chk("unmapped", q, 0);
        $display("meter test done");
    endtask
    task t_run;
        @(posedge clk);
        run <= 1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("running", runo, 0);
        @(posedge clk);
        ps <= 1;
        @(posedge clk);
        ps <= 0;
        @(negedge clk);
        chk("running", runo, 1);
        $display("run test done");
    endtask
    task give_verdict;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1;
        repeat (3) @(posedge clk);
        t_gate;
        t_meters;
        t_run;
        give_verdict;
    end
    initial
    begin
        #100000;
        errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
